// >>> hdl/tast_core.sv
// design: sample clock, trace capture and duration trigger of the external timing analyzer
`timescale 1ns/1ps
`default_nettype none
module tast_core
  import tast_pkg::*;
#(
  parameter int DEPTH = 1024
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] probe_in,
  output logic irq,
  output logic trig_out
);
  localparam int MAW = $clog2(DEPTH);
  localparam int CW = MAW + 1;

  generate
    if (DEPTH < LIM_STD || TICK_CYC > 256)
    begin : g_chk
      $error("tast_core: DEPTH too small or tick divider too large");
    end
  endgenerate

  // -----------------------------------------------------------------------------
  // decoding helpers
  // -----------------------------------------------------------------------------
  function automatic logic [XW:0] to_ticks(input logic [15:0] v, input logic [1:0] u);
    logic [XW-1:0] ns;
    begin
      case (u)
        U_NS: ns = XW'(v);
        U_US: ns = XW'(v) * XW'(NS_PER_US);
        U_MS: ns = XW'(v) * XW'(NS_PER_MS);
        default: ns = '0;
      endcase
      to_ticks = {(u != 2'h3) && (ns % XW'(BASE_TICK_NS) == '0), ns / XW'(BASE_TICK_NS)};
    end
  endfunction

  function automatic logic is_125(input logic [XW-1:0] t);
    logic [XW-1:0] r;
    begin
      r = t;
      for (int i = 0; i < 7; i++)
      begin
        if (r >= 40'ha && r % 40'ha == '0)
          r = r / 40'ha;
      end
      is_125 = (r == 40'h1) || (r == 40'h2) || (r == 40'h5);
    end
  endfunction

  function automatic logic period_ok(input logic [XW:0] tk, input tast_mode_t m);
    begin
      unique case (m)
        TAST_STD: period_ok = tk[XW] && tk[XW-1:0] >= SP_STD_MIN_T && tk[XW-1:0] <= SP_MAX_T && is_125(tk[XW-1:0]);
        TAST_GLI: period_ok = tk[XW] && tk[XW-1:0] >= SP_GLI_MIN_T && tk[XW-1:0] <= SP_MAX_T && is_125(tk[XW-1:0]);
        TAST_TRN: period_ok = tk[XW] && tk[XW-1:0] == SP_TRN_T;
        default: period_ok = 1'b0;
      endcase
    end
  endfunction

  // -----------------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------------
  logic [NCH-1:0] meta_r, sync_r, prev_r, last_r, last_nxt;
  logic [NCH-1:0] seen_r, seen_nxt, gacc_r, gacc_nxt;
  tast_mode_t mode_r, mode_nxt;
  logic arm_r, arm_nxt;
  logic [TW-1:0] period_r, period_nxt, dur_r, dur_nxt, hcnt_r, hcnt_nxt, bo_r, bo_nxt, sp_r, sp_nxt;
  logic [17:0] per_raw_r, per_raw_nxt, dur_raw_r, dur_raw_nxt;
  logic dur_lt_r, dur_lt_nxt, dur_en_r, dur_en_nxt;
  tast_expr_t expr_r, expr_nxt;
  tast_pat_t pat_a_r, pat_a_nxt, pat_b_r, pat_b_nxt;
  tast_qual_t qual_r, qual_nxt;
  logic [NST-1:0] sts_r, sts_nxt, msk_r, msk_nxt, sts_set, sts_clr;
  logic [MAW-1:0] taddr_r, taddr_nxt;
  tast_state_t state_r, state_nxt;
  logic [7:0] tick_r, tick_nxt;
  logic [15:0] delta_r, delta_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt, tidx_r, tidx_nxt, limit;
  logic [31:0] prdata_r, prdata_nxt, rd;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt, trig_r, trig_nxt;
  logic [31:0] mem [DEPTH];
  logic mem_we;
  logic [31:0] mem_wd;
  logic [XW:0] tk;

  // -----------------------------------------------------------------------------
  // pattern and qualifier decode
  // -----------------------------------------------------------------------------
  logic hit_a, hit_b, expr_true, tick_en, edge_hit, gl_hit, mapped, ans, wr;
  logic [NCH-1:0] chg;

  always_comb
  begin
    hit_a = ((sync_r ^ pat_a_r.value) & pat_a_r.mask) == '0;
    hit_b = ((sync_r ^ pat_b_r.value) & pat_b_r.mask) == '0;
    unique case (expr_r)
      EX_ANY, EX_ALL: expr_true = 1'b1;
      EX_NONE, EX_NEVER: expr_true = 1'b0;
      EX_ONE: expr_true = hit_a;
      EX_AND: expr_true = hit_a && hit_b;
      default: expr_true = 1'b0;
    endcase
    tick_en = tick_r == 8'(TICK_CYC - 1);
    chg = sync_r ^ prev_r;
    edge_hit = ((qual_r.edge_pol == EP_RISE || qual_r.edge_pol == EP_BOTH) && sync_r[qual_r.edge_ch] && !prev_r[qual_r.edge_ch])
      || ((qual_r.edge_pol == EP_FALL || qual_r.edge_pol == EP_BOTH) && !sync_r[qual_r.edge_ch] && prev_r[qual_r.edge_ch]);
    gl_hit = qual_r.gl_en && chg[qual_r.gl_ch] && seen_r[qual_r.gl_ch];
    unique case (mode_r)
      TAST_STD: limit = CW'(LIM_STD);
      TAST_GLI: limit = CW'(LIM_GLI);
      TAST_TRN: limit = CW'(LIM_TRN);
      default: limit = CW'(LIM_TRN);
    endcase
    ans = psel && penable && !pready_r;
    wr = psel && penable && pready_r && pwrite && !pslverr_r;
    tk = to_ticks(pwdata[15:0], pwdata[17:16]);
  end

  // -----------------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------------
  always_comb
  begin
    last_nxt = last_r;
    seen_nxt = seen_r | chg;
    gacc_nxt = gacc_r | (chg & seen_r);
    mode_nxt = mode_r;
    arm_nxt = arm_r;
    period_nxt = period_r;
    per_raw_nxt = per_raw_r;
    dur_nxt = dur_r;
    dur_raw_nxt = dur_raw_r;
    dur_lt_nxt = dur_lt_r;
    dur_en_nxt = dur_en_r;
    expr_nxt = expr_r;
    pat_a_nxt = pat_a_r;
    pat_b_nxt = pat_b_r;
    qual_nxt = qual_r;
    msk_nxt = msk_r;
    taddr_nxt = taddr_r;
    state_nxt = state_r;
    hcnt_nxt = hcnt_r;
    bo_nxt = bo_r;
    sp_nxt = sp_r;
    delta_nxt = delta_r;
    cnt_nxt = cnt_r;
    tidx_nxt = tidx_r;
    tick_nxt = tick_en ? 8'h00 : tick_r + 8'h01;
    trig_nxt = 1'b0;
    sts_set = '0;
    sts_clr = '0;
    mem_we = 1'b0;
    mem_wd = {16'h0000, sync_r};
    // capture: sampled modes store on the period strobe, transitional on change
    if (tick_en)
    begin
      if (mode_r == TAST_TRN)
      begin
        if (sync_r != last_r)
        begin
          mem_we = arm_r && cnt_r < limit;
          mem_wd = {delta_r, sync_r};
          last_nxt = sync_r;
          delta_nxt = 16'h0001;
        end
        else if (delta_r != 16'hffff)
          delta_nxt = delta_r + 16'h0001;
      end
      else if (sp_r + TW'(1) >= period_r)
      begin
        sp_nxt = '0;
        mem_we = arm_r && cnt_r < limit;
        mem_wd = {(mode_r == TAST_GLI) ? gacc_nxt : 16'h0000, sync_r};
        seen_nxt = '0;
        gacc_nxt = '0;
      end
      else
        sp_nxt = sp_r + TW'(1);
    end
    if (mem_we)
    begin
      cnt_nxt = cnt_r + CW'(1);
      if (cnt_r + CW'(1) == limit)
        sts_set[ST_FULL] = 1'b1;
    end
    // trigger sequencer, advanced once per base tick
    if (tick_en)
    begin
      unique case (state_r)
        TS_IDLE, TS_DONE:
          state_nxt = state_r;
        TS_SEEK:
          if (expr_true)
          begin
            hcnt_nxt = TW'(1);
            state_nxt = dur_en_r ? TS_HOLD : ((qual_r.edge_pol != 2'h0 || qual_r.gl_en) ? TS_QUAL : TS_DONE);
            trig_nxt = !dur_en_r && qual_r.edge_pol == 2'h0 && !qual_r.gl_en;
          end
        TS_HOLD:
        begin
          if (!dur_lt_r)
          begin
            if (!expr_true)
              state_nxt = TS_BACKOFF;
            else if (hcnt_r + TW'(1) >= dur_r)
              state_nxt = TS_QUAL;
            else
              hcnt_nxt = hcnt_r + TW'(1);
          end
          else if (expr_true)
          begin
            if (hcnt_r >= dur_r)
              state_nxt = TS_BACKOFF;
            else
              hcnt_nxt = hcnt_r + TW'(1);
          end
          else if (hcnt_r >= LT_STABLE_T)
            state_nxt = TS_QUAL;
          else
            state_nxt = TS_BACKOFF;
          bo_nxt = BACKOFF_T;
        end
        TS_QUAL:
          if ((qual_r.edge_pol == 2'h0 && !qual_r.gl_en) || (qual_r.edge_pol != 2'h0 && edge_hit) || gl_hit)
          begin
            state_nxt = TS_DONE;
            trig_nxt = 1'b1;
          end
        TS_BACKOFF:
          if (bo_r <= TW'(1))
            state_nxt = TS_SEEK;
          else
            bo_nxt = bo_r - TW'(1);
        default:
          state_nxt = TS_IDLE;
      endcase
    end
    if (trig_nxt)
    begin
      sts_set[ST_TRIG] = 1'b1;
      tidx_nxt = cnt_r;
    end
    // register bus: answer one cycle into the access phase
    pready_nxt = ans;
    pslverr_nxt = ans && !mapped;
    prdata_nxt = (ans && !pwrite) ? rd : prdata_r;
    if (wr)
    begin
      unique case (paddr)
        REG_CTRL:
        begin
          if (pwdata[1:0] != 2'h3)
            mode_nxt = tast_mode_t'(pwdata[1:0]);
          if (pwdata[1:0] == TAST_TRN)
          begin
            period_nxt = RST_PERIOD_T;
            per_raw_nxt = RST_PER_RAW;
          end
          else if (pwdata[1:0] == TAST_GLI && XW'(period_r) < SP_GLI_MIN_T)
          begin
            period_nxt = TW'(SP_GLI_MIN_T);
            per_raw_nxt = {U_NS, 16'(SP_GLI_MIN_NS)};
          end
          arm_nxt = pwdata[CTRL_ARM_BIT];
          if (pwdata[CTRL_ARM_BIT] && !arm_r)
          begin
            state_nxt = TS_SEEK;
            cnt_nxt = '0;
            sp_nxt = '0;
          end
          else if (!pwdata[CTRL_ARM_BIT])
            state_nxt = TS_IDLE;
        end
        REG_PERIOD:
          if (period_ok(tk, mode_r))
          begin
            period_nxt = TW'(tk[XW-1:0]);
            per_raw_nxt = pwdata[17:0];
          end
          else
            sts_set[ST_PREJ] = 1'b1;
        REG_DUR:
          if (!pwdata[DUR_EN_BIT] || (tk[XW] && tk[XW-1:0] <= DUR_MAX_T
            && tk[XW-1:0] >= (pwdata[DUR_LT_BIT] ? DUR_LT_MIN_T : DUR_GT_MIN_T)))
          begin
            dur_nxt = TW'(tk[XW-1:0]);
            dur_raw_nxt = pwdata[17:0];
            dur_lt_nxt = pwdata[DUR_LT_BIT];
            dur_en_nxt = pwdata[DUR_EN_BIT];
          end
          else
            sts_set[ST_DREJ] = 1'b1;
        REG_EXPR:
          if (pwdata[2:0] <= EX_AND)
            expr_nxt = tast_expr_t'(pwdata[2:0]);
        REG_PATA: pat_a_nxt = pwdata;
        REG_PATB: pat_b_nxt = pwdata;
        REG_QUAL: qual_nxt = pwdata[10:0];
        REG_STS: sts_clr = pwdata[NST-1:0];
        REG_MSK: msk_nxt = pwdata[NST-1:0];
        REG_INIT:
          if (pwdata[0])
          begin
            mode_nxt = RST_MODE;
            period_nxt = RST_PERIOD_T;
            per_raw_nxt = RST_PER_RAW;
            expr_nxt = RST_EXPR;
            dur_en_nxt = 1'b0;
          end
        REG_TADDR: taddr_nxt = pwdata[MAW-1:0];
        default: taddr_nxt = taddr_r;
      endcase
    end
    // a hardware event in the clearing cycle survives
    sts_nxt = (sts_r & ~sts_clr) | sts_set;
    irq_nxt = |(sts_r & msk_r);
  end

  // -----------------------------------------------------------------------------
  // read decode
  // -----------------------------------------------------------------------------
  always_comb
  begin
    mapped = 1'b1;
    unique case (paddr)
      REG_CTRL: rd = {29'h0, arm_r, mode_r};
      REG_PERIOD: rd = {14'h0, per_raw_r};
      REG_DUR: rd = {12'h0, dur_en_r, dur_lt_r, dur_raw_r};
      REG_EXPR: rd = {29'h0, expr_r};
      REG_PATA: rd = pat_a_r;
      REG_PATB: rd = pat_b_r;
      REG_QUAL: rd = {21'h0, qual_r};
      REG_STS: rd = 32'(sts_r);
      REG_MSK: rd = 32'(msk_r);
      REG_INIT: rd = 32'h0;
      REG_TADDR: rd = 32'(taddr_r);
      REG_TDATA: rd = mem[taddr_r];
      REG_CNT: rd = 32'(cnt_r) | (32'(tidx_r) << 16) | (32'(state_r) << 28);
      default:
      begin
        rd = 32'h0;
        mapped = 1'b0;
      end
    endcase
  end

  // -----------------------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      last_r <= '0;
      seen_r <= '0;
      gacc_r <= '0;
      mode_r <= RST_MODE;
      arm_r <= 1'b0;
      period_r <= RST_PERIOD_T;
      per_raw_r <= RST_PER_RAW;
      dur_r <= '0;
      dur_raw_r <= '0;
      dur_lt_r <= 1'b0;
      dur_en_r <= 1'b0;
      expr_r <= RST_EXPR;
      pat_a_r <= '0;
      pat_b_r <= '0;
      qual_r <= '0;
      sts_r <= '0;
      msk_r <= '0;
      taddr_r <= '0;
      state_r <= TS_IDLE;
      hcnt_r <= '0;
      bo_r <= '0;
      sp_r <= '0;
      tick_r <= '0;
      delta_r <= '0;
      cnt_r <= '0;
      tidx_r <= '0;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
      trig_r <= 1'b0;
    end
    else if (ce)
    begin
      meta_r <= probe_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      last_r <= last_nxt;
      seen_r <= seen_nxt;
      gacc_r <= gacc_nxt;
      mode_r <= mode_nxt;
      arm_r <= arm_nxt;
      period_r <= period_nxt;
      per_raw_r <= per_raw_nxt;
      dur_r <= dur_nxt;
      dur_raw_r <= dur_raw_nxt;
      dur_lt_r <= dur_lt_nxt;
      dur_en_r <= dur_en_nxt;
      expr_r <= expr_nxt;
      pat_a_r <= pat_a_nxt;
      pat_b_r <= pat_b_nxt;
      qual_r <= qual_nxt;
      sts_r <= sts_nxt;
      msk_r <= msk_nxt;
      taddr_r <= taddr_nxt;
      state_r <= state_nxt;
      hcnt_r <= hcnt_nxt;
      bo_r <= bo_nxt;
      sp_r <= sp_nxt;
      tick_r <= tick_nxt;
      delta_r <= delta_nxt;
      cnt_r <= cnt_nxt;
      tidx_r <= tidx_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
      trig_r <= trig_nxt;
    end
  end

  // trace memory has no reset; the record count says what is valid
  always_ff @(posedge ref_clk)
  begin
    if (ce && mem_we)
      mem[cnt_r[MAW-1:0]] <= mem_wd;
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign trig_out = trig_r;
endmodule
`default_nettype wire

// >>> hdl/tast_pkg.sv
// package: constants, field layouts and types of the timing analyzer sample and trigger block
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
package tast_pkg;
  localparam int NCH = 16;
  localparam int AW = 8;
  localparam int XW = 40;
  localparam int TW = 23;
  localparam int CLK_PERIOD_NS = 100;
  localparam int BASE_TICK_NS = 10;
  localparam int TICK_CYC = (BASE_TICK_NS / CLK_PERIOD_NS < 1) ? 1 : BASE_TICK_NS / CLK_PERIOD_NS;
  localparam longint NS_PER_US = 1000;
  localparam longint NS_PER_MS = 1000000;
  // -----------------------------------------------------------------------------
  // times, kept in ns and turned into base ticks
  // -----------------------------------------------------------------------------
  localparam longint SP_STD_MIN_NS = 10;
  localparam longint SP_GLI_MIN_NS = 20;
  localparam longint SP_MAX_NS = 50000000;
  localparam longint SP_TRN_NS = 10;
  localparam longint DUR_GT_MIN_NS = 30;
  localparam longint DUR_LT_MIN_NS = 40;
  localparam longint DUR_MAX_NS = 10000000;
  localparam longint BACKOFF_NS = 20;
  localparam longint LT_STABLE_NS = 20;
  localparam logic [XW-1:0] SP_STD_MIN_T = XW'(SP_STD_MIN_NS / BASE_TICK_NS);
  localparam logic [XW-1:0] SP_GLI_MIN_T = XW'(SP_GLI_MIN_NS / BASE_TICK_NS);
  localparam logic [XW-1:0] SP_MAX_T = XW'(SP_MAX_NS / BASE_TICK_NS);
  localparam logic [XW-1:0] SP_TRN_T = XW'(SP_TRN_NS / BASE_TICK_NS);
  localparam logic [XW-1:0] DUR_GT_MIN_T = XW'(DUR_GT_MIN_NS / BASE_TICK_NS);
  localparam logic [XW-1:0] DUR_LT_MIN_T = XW'(DUR_LT_MIN_NS / BASE_TICK_NS);
  localparam logic [XW-1:0] DUR_MAX_T = XW'(DUR_MAX_NS / BASE_TICK_NS);
  localparam logic [TW-1:0] BACKOFF_T = TW'(BACKOFF_NS / BASE_TICK_NS);
  localparam logic [TW-1:0] LT_STABLE_T = TW'(LT_STABLE_NS / BASE_TICK_NS);
  localparam int LIM_STD = 1024;
  localparam int LIM_GLI = 512;
  localparam int LIM_TRN = 512;
  // -----------------------------------------------------------------------------
  // register offsets and fields
  // -----------------------------------------------------------------------------
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_PERIOD = 8'h04;
  localparam logic [AW-1:0] REG_DUR = 8'h08;
  localparam logic [AW-1:0] REG_EXPR = 8'h0c;
  localparam logic [AW-1:0] REG_PATA = 8'h10;
  localparam logic [AW-1:0] REG_PATB = 8'h14;
  localparam logic [AW-1:0] REG_QUAL = 8'h18;
  localparam logic [AW-1:0] REG_STS = 8'h1c;
  localparam logic [AW-1:0] REG_MSK = 8'h20;
  localparam logic [AW-1:0] REG_INIT = 8'h24;
  localparam logic [AW-1:0] REG_TADDR = 8'h28;
  localparam logic [AW-1:0] REG_TDATA = 8'h2c;
  localparam logic [AW-1:0] REG_CNT = 8'h30;
  localparam int CTRL_ARM_BIT = 2;
  localparam int DUR_LT_BIT = 18;
  localparam int DUR_EN_BIT = 19;
  localparam int NST = 4;
  localparam int ST_TRIG = 0;
  localparam int ST_PREJ = 1;
  localparam int ST_DREJ = 2;
  localparam int ST_FULL = 3;
  localparam logic [1:0] EP_RISE = 2'h1;
  localparam logic [1:0] EP_FALL = 2'h2;
  localparam logic [1:0] EP_BOTH = 2'h3;
  typedef enum logic [1:0] {TAST_STD, TAST_GLI, TAST_TRN} tast_mode_t;
  typedef enum logic [1:0] {U_NS, U_US, U_MS} tast_unit_t;
  typedef enum logic [2:0] {EX_ANY, EX_ALL, EX_NONE, EX_NEVER, EX_ONE, EX_AND} tast_expr_t;
  typedef enum logic [2:0] {TS_IDLE, TS_SEEK, TS_HOLD, TS_QUAL, TS_BACKOFF, TS_DONE} tast_state_t;
  typedef struct packed {logic [NCH-1:0] mask; logic [NCH-1:0] value;} tast_pat_t;
  typedef struct packed {logic gl_en; logic [3:0] gl_ch; logic [1:0] edge_pol; logic [3:0] edge_ch;} tast_qual_t;
  localparam tast_mode_t RST_MODE = TAST_TRN;
  localparam logic [TW-1:0] RST_PERIOD_T = TW'(SP_TRN_T);
  localparam logic [17:0] RST_PER_RAW = {U_NS, 16'h000a};
  localparam tast_expr_t RST_EXPR = EX_ANY;
endpackage

// >>> testbench/tast_chk.sv
// checker: bus handshake and trigger output properties
`timescale 1ns/1ps
`default_nettype none
module tast_chk
  import tast_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic trig_out
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // ----
  // bus answer
  // ----
  AST_ANSWER: assert property (psel && penable && !pready && ce |=> pready) else $error("late answer");
  AST_READY_ONE: assert property (pready && ce |=> !pready) else $error("ready too long");
  AST_READY_ACC: assert property (pready |-> psel && penable) else $error("ready outside access");
  AST_ERR: assert property (pslverr |-> pready) else $error("error without ready");
  AST_ERR_DATA: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
  AST_RDATA: assert property ($changed(prdata) |-> pready && !pwrite) else $error("read data moved");
  // ----
  // trigger
  // ----
  // a new trigger needs a disarm and an arm write, so pulses sit far apart
  AST_TRIG_GAP: assert property (trig_out |=> !trig_out [*4]) else $error("trigger repeats");
  AST_FREEZE: assert property (!ce |=> $stable(prdata) && $stable(trig_out) && $stable(irq))
    else $error("moved while frozen");
endmodule
`default_nettype wire

// >>> testbench/tast_tgt.sv
// partner: target system on the sixteen probe channels
`timescale 1ns/1ps
`default_nettype none
module tast_tgt
  import tast_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [NCH-1:0] drv,
  output logic [NCH-1:0] probe_in
);
  // outputs move just after the edge, so the sync flops see a clean level
  initial probe_in = '0;
  always @(posedge ref_clk) probe_in <= drv;
endmodule
`default_nettype wire

// >>> testbench/timing_analyzer_sample_trigger_test.sv
// testbench: sample period, duration and trigger checks
`timescale 1ns/1ps
`default_nettype none
module timing_analyzer_sample_trigger_test
  import tast_pkg::*;
;
  logic ref_clk = 1'b0, rstn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, rn;
  logic pready, pslverr, irq, trig_out, er;
  logic [NCH-1:0] drv = '0, probe_in;
  logic [31:0] seed = 32'h3873dd67;
  int errors = 0, comparisons = 0, ntrig = 0;
  logic [17:0] ptab [6] = '{18'h0000a, 18'h00014, 18'h0001e, 18'h10002, 18'h20032, 18'h20064};
  logic [19:0] dtab [8] = '{20'h80014, 20'h8001e, 20'hc001e, 20'hc0028, 20'h80023, 20'ha000a, 20'ha000b, 20'h0ffff};
  int vals [9] = '{1, 2, 5, 10, 20, 50, 100, 200, 500};
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (trig_out === 1'b1) ntrig <= ntrig + 1;
  tast_core i_dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .probe_in(probe_in),
    .irq(irq), .trig_out(trig_out));
  tast_tgt i_tgt (.ref_clk(ref_clk), .drv(drv), .probe_in(probe_in));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic longint ns_of(logic [17:0] r);
    return r[17:16] == 2'h3 ? -1 : longint'(r[15:0]) * (r[17] ? 1000000 : r[16] ? 1000 : 1);
  endfunction
  // ----
  // reference model of what the block accepts
  // ----
  function automatic bit pok(int m, logic [17:0] r);
    longint ns;
    bit ok;
    ns = ns_of(r);
    ok = ns >= (m == 1 ? 20 : 10) && ns <= 50000000 && (m != 2 || ns == 10);
    while (ns > 0 && ns % 10 == 0) ns = ns / 10;
    return ok && (ns == 1 || ns == 2 || ns == 5);
  endfunction
  function automatic bit dok(logic [19:0] r);
    longint ns;
    ns = ns_of(r[17:0]);
    return !r[19] || (ns % 10 == 0 && ns <= 10000000 && ns >= (r[18] ? 40 : 30));
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 20), 32'h1);
  endtask
  task automatic rearm(input logic [1:0] m);
    bus(1'b1, REG_CTRL, {29'h0, 1'b0, m});
    bus(1'b1, REG_CTRL, {29'h0, 1'b1, m});
  endtask
  task automatic wt(input int n, input int exp);
    int t0;
    t0 = ntrig;
    repeat (n) @(posedge ref_clk);
    chk(32'(ntrig - t0), 32'(exp));
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #2000000;
    errors++;
    results();
  end
  initial
  begin
    logic [17:0] p;
    logic [19:0] d;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(1'b0, REG_PERIOD, 32'h0);
    chk(rd, 32'h0000000a);
    bus(1'b0, REG_EXPR, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h3c, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    for (int m = 0; m < 3; m++)
    begin
      bus(1'b1, REG_CTRL, 32'(m));
      for (int i = 0; i < 12; i++)
      begin
        rn = xs();
        p = i < 6 ? ptab[i] : {rn[17:16], 16'(vals[rn[31:20] % 9])};
        bus(1'b1, REG_PERIOD, 32'(p));
        bus(1'b0, REG_STS, 32'h0);
        chk(32'(rd[1]), 32'(!pok(m, p)));
        bus(1'b1, REG_STS, 32'h2);
        if (pok(m, p))
        begin
          bus(1'b0, REG_PERIOD, 32'h0);
          chk(rd, 32'(p));
        end
      end
    end
    chk(32'(irq), 32'h0);
    for (int i = 0; i < 12; i++)
    begin
      rn = xs();
      d = i < 8 ? dtab[i] : {1'b1, rn[0], rn[17:16], 16'(rn[31:20] % 2000)};
      bus(1'b1, REG_DUR, 32'(d));
      bus(1'b0, REG_STS, 32'h0);
      chk(32'(rd[2]), 32'(!dok(d)));
      bus(1'b1, REG_STS, 32'h4);
    end
    // greater-than 50 ns: one tick short must not fire
    bus(1'b1, REG_CTRL, 32'h0);
    bus(1'b1, REG_PATA, 32'h000f0005);
    bus(1'b1, REG_EXPR, 32'h4);
    bus(1'b1, REG_MSK, 32'h1);
    bus(1'b1, REG_DUR, 32'h00080032);
    rearm(2'h0);
    drv <= 16'h0015;
    repeat (4) @(posedge ref_clk);
    drv <= 16'h0000;
    wt(12, 0);
    drv <= 16'h00a5;
    wt(5, 0);
    wt(10, 1);
    chk(32'(irq), 32'h1);
    bus(1'b1, REG_STS, 32'h1);
    bus(1'b0, REG_STS, 32'h0);
    chk({rd[0], 31'(irq)}, 32'h0);
    drv <= 16'h0000;
    bus(1'b1, REG_DUR, 32'h000c0032);
    rearm(2'h0);
    drv <= 16'h0005;
    @(posedge ref_clk);
    drv <= 16'h0000;
    wt(12, 0);
    drv <= 16'h0005;
    wt(3, 0);
    drv <= 16'h0000;
    wt(12, 1);
    bus(1'b1, REG_INIT, 32'h1);
    bus(1'b0, REG_EXPR, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, REG_PERIOD, 32'h0);
    chk(rd, 32'h0000000a);
    bus(1'b1, REG_QUAL, 32'h00000018);
    rearm(2'h2);
    wt(10, 0);
    drv <= 16'h0100;
    wt(10, 1);
    bus(1'b1, REG_QUAL, 32'h0);
    bus(1'b1, REG_EXPR, 32'h3);
    rearm(2'h2);
    repeat (20)
    begin
      rn = xs();
      drv <= rn[15:0];
      wt(1, 0);
    end
    ce <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ce <= 1'b1;
    bus(1'b1, REG_EXPR, 32'h0);
    rearm(2'h2);
    wt(10, 1);
    // trace: steady probes, standard mode at 10 ns stores one record per tick until full
    drv <= 16'h0c3a;
    rearm(2'h0);
    repeat (1100) @(posedge ref_clk);
    bus(1'b0, REG_CNT, 32'h0);
    chk(32'(rd[10:0]), 32'(LIM_STD));
    bus(1'b0, REG_STS, 32'h0);
    chk(32'(rd[3]), 32'h1);
    bus(1'b1, REG_TADDR, 32'h5);
    bus(1'b0, REG_TDATA, 32'h0);
    chk(rd, 32'h00000c3a);
    // glitch mode lifts 10 ns to 20 ns: a record every 2 ticks, count taken 602 ticks after arming
    rearm(2'h1);
    repeat (600) @(posedge ref_clk);
    bus(1'b0, REG_CNT, 32'h0);
    chk(32'(rd[10:0]), 32'd301);
    repeat (500) @(posedge ref_clk);
    bus(1'b0, REG_CNT, 32'h0);
    chk(32'(rd[10:0]), 32'(LIM_GLI));
    // glitch qualifier on channel 9 in a 50 us window: only the second change fires
    bus(1'b1, REG_QUAL, 32'h00000640);
    bus(1'b1, REG_PERIOD, 32'h00010032);
    rearm(2'h1);
    drv <= 16'h0e3a;
    wt(10, 0);
    drv <= 16'h0c3a;
    wt(10, 1);
    // a second reset mid-run brings back the defaults
    bus(1'b1, REG_EXPR, 32'h3);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(1'b0, REG_PERIOD, 32'h0);
    chk(rd, 32'h0000000a);
    bus(1'b0, REG_EXPR, 32'h0);
    chk(rd, 32'h0);
    results();
  end
endmodule
bind tast_core tast_chk i_chk (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .trig_out(trig_out));
`default_nettype wire
